// ---- hw/lamp_blinker.sv ----
// Purpose: shared free-running flash phase generator
// Assumes: one clock, active-low asynchronous reset
// Notes: all lamps read the same phases so equal rates stay in phase
`timescale 1ns/1ps
module lamp_blinker #(
   parameter int unsigned SLOW_HALF = 40_000_000,
   parameter int unsigned FAST_HALF = 10_000_000,
   parameter int unsigned VAR_HALF  = 20_000_000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      slow_ph,
   output logic      fast_ph,
   output logic      var_ph
);
   logic [31:0] slow_q, fast_q, var_q;
   logic        slow_ph_q, fast_ph_q, var_ph_q;
   logic        var_sel_q;
   wire         slow_wrap = (slow_q == 32'(SLOW_HALF - 1));
   wire         fast_wrap = (fast_q == 32'(FAST_HALF - 1));
   wire         var_wrap  = (var_q  == (var_sel_q ? 32'(VAR_HALF - 1) : 32'(FAST_HALF - 1)));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_q    <= 32'h0;
         fast_q    <= 32'h0;
         var_q     <= 32'h0;
         slow_ph_q <= 1'b0;
         fast_ph_q <= 1'b0;
         var_ph_q  <= 1'b0;
         var_sel_q <= 1'b0;
      end else begin
         slow_q    <= slow_wrap ? 32'h0 : slow_q + 32'h1;
         fast_q    <= fast_wrap ? 32'h0 : fast_q + 32'h1;
         var_q     <= var_wrap ? 32'h0 : var_q + 32'h1;
         slow_ph_q <= slow_wrap ? ~slow_ph_q : slow_ph_q;
         fast_ph_q <= fast_wrap ? ~fast_ph_q : fast_ph_q;
         var_ph_q  <= var_wrap ? ~var_ph_q : var_ph_q;
         // variable rate alternates between two half periods
         var_sel_q <= var_wrap ? ~var_sel_q : var_sel_q;
      end
   end

   assign slow_ph = slow_ph_q;
   assign fast_ph = fast_ph_q;
   assign var_ph  = var_ph_q;

   chk_fast_shorter: assert property (@(posedge pclk) disable iff (!presetn)
      FAST_HALF < SLOW_HALF) else $error("fast flash not shorter than slow");
endmodule

// ---- hw/lamp_pkg.sv ----
// Purpose: constants, types and register map of the status lamp encoder
// Assumes: 40 MHz pclk, APB with 32-bit data
// Notes: lamp outputs are colour plus flash mode per lamp
// Operation
// - after power-up the state lamp shows orange until start-up completes.
// - state lamp uses on, slow, fast; safety lamp off, on, slow, fast; link lamp off, on, slow; fieldbus lamp adds variable to off, on, slow, fast.
// - no fault and nothing higher: state lamp steady green.
// - commissioning or factory reset: state lamp green slow flash.
// - firmware done, awaiting power cycle: state and fieldbus lamps red slow.
// - fault present: state lamp red fast.
// - wrong card or failed firmware: state and fieldbus lamps red fast.
// - safety enabled but none active: safety lamp steady yellow.
// - safety active without safety fault: safety lamp yellow slow.
// - safety fault: stop response raised and safety lamp yellow fast.
// - healthy network communication: link lamp steady green.
// - device naming active: link lamp green slow.
// - no network communication: link lamp off.
// - network variant with process data exchange: fieldbus lamp off.
// - network variant, bus up but no data: fieldbus red slow, unless state red slow.
// - network variant bad parameters, card or firmware: both lamps red fast.
// - network variant without connection: fieldbus red fast, unless state red fast.
// - serial variants with monitoring setting zero: fieldbus lamp dark.
// - profibus variant: data exchange green steady, unused interface off.
// - profibus configuration fault: fieldbus red slow, unless state red slow.
// - profibus bus error: fieldbus red fast, unless state red fast.
// - slow flash runs at 0.5 Hz.
package lamp_pkg;

   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned SLOW_MHZ      = 500;      // 0.5 Hz in millihertz
   localparam int unsigned FAST_HZ       = 2;
   // half periods in cycles
   localparam int unsigned SLOW_HALF_CYC = CLK_HZ;   // 1 s half of 2 s period
   localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
   localparam int unsigned BOOT_CYC      = CLK_HZ;   // orange phase after reset

   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_COND   = 12'h004;
   localparam logic [11:0] ADDR_LAMPS  = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;

   // control register fields
   localparam int unsigned CTRL_START  = 0;
   localparam int unsigned CTRL_FAULT  = 1;
   localparam int unsigned CTRL_VAR_LO = 4;   // two bits of bus variant
   localparam int unsigned CTRL_MON_LO = 8;   // eight bits of monitoring setting
   localparam logic [7:0]  MON_OFF     = 8'h00;

   typedef enum logic [1:0] {
      VAR_PROFINET = 2'h0,
      VAR_PROFIBUS = 2'h1,
      VAR_SERIAL   = 2'h2
   } variant_t;

   typedef enum logic [2:0] {
      FL_OFF  = 3'h0,
      FL_ON   = 3'h1,
      FL_SLOW = 3'h2,
      FL_FAST = 3'h3,
      FL_VAR  = 3'h4
   } flash_t;

   typedef enum logic [2:0] {
      COL_NONE   = 3'h0,
      COL_GREEN  = 3'h1,
      COL_RED    = 3'h2,
      COL_YELLOW = 3'h3,
      COL_ORANGE = 3'h4
   } colour_t;

   typedef struct packed {
      colour_t colour;
      flash_t  mode;
      logic    lit;
   } lamp_t;

   // condition register bit positions
   typedef struct packed {
      logic bus_error;        // 15
      logic baud_search;      // 14
      logic bus_config_fault; // 13
      logic bus_unused;       // 12
      logic bus_no_link;      // 11
      logic bus_no_data;      // 10
      logic bus_data_active;  // 9
      logic bad_params;       // 8
      logic pn_naming;        // 7
      logic pn_ok;            // 6
      logic safety_fault;     // 5
      logic safety_active;    // 4
      logic safety_enabled;   // 3
      logic fw_updating;      // 2
      logic fw_wait_cycle;    // 1
      logic fw_bad_or_card;   // 0
   } cond_t;

   typedef enum logic [4:0] {
      ST_BOOT  = 5'h01,
      ST_FW    = 5'h02,
      ST_FAULT = 5'h04,
      ST_COMM  = 5'h08,
      ST_READY = 5'h10
   } rdy_state_t;

endpackage

// ---- hw/status_lamp_encoder.sv ----
// Purpose: encodes drive diagnostic conditions into four lamp patterns
// Assumes: conditions written by firmware over APB; 40 MHz pclk
// Notes: outputs give colour, flash mode and the instantaneous lit level
`timescale 1ns/1ps
module status_lamp_encoder
   import lamp_pkg::*;
#(
   parameter int unsigned BOOT_CYCLES = lamp_pkg::BOOT_CYC,
   parameter int unsigned SLOW_HALF   = lamp_pkg::SLOW_HALF_CYC,
   parameter int unsigned FAST_HALF   = lamp_pkg::FAST_HALF_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output lamp_pkg::lamp_t  state_lamp,
   output lamp_pkg::lamp_t  fieldbus_lamp,
   output lamp_pkg::lamp_t  safety_lamp,
   output lamp_pkg::lamp_t  link_lamp,
   output logic             stop_request
);
   import lamp_pkg::*;

   // ---------------- APB slave ----------------
   logic [31:0] ctrl_q;
   cond_t       cond_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   wire acc_new  = psel && penable && !pready_q;
   wire acc      = psel && penable && pready_q;
   // unmapped offsets: writes dropped, reads give zero with an error
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_cond = (paddr == ADDR_COND);
   wire hit_lmp  = (paddr == ADDR_LAMPS);
   wire hit_stat = (paddr == ADDR_STATUS);
   wire mapped   = hit_ctrl || hit_cond || hit_lmp || hit_stat;
   wire wr_ok    = acc && pwrite;

   variant_t   variant;
   logic [7:0] mon_setting;
   assign variant     = variant_t'(ctrl_q[CTRL_VAR_LO +: 2]);
   assign mon_setting = ctrl_q[CTRL_MON_LO +: 8];

   lamp_t      st_q, fb_q, sf_q, lk_q;
   rdy_state_t rdy_q, rdy_d;
   logic       stop_q;
   logic [31:0] boot_q;

   wire [31:0] lamp_word = {4'h0, st_q, fb_q, sf_q, lk_q};
   wire [31:0] stat_word = {26'h0, stop_q, rdy_q};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                        hit_cond ? {16'h0, cond_q} :
                        hit_lmp  ? lamp_word :
                        hit_stat ? stat_word : 32'h0;

   // one wait state: answer is ready on the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= acc_new;
         pslverr_q <= acc_new && !mapped;
         prdata_q  <= (acc_new && !pwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 32'h0;
         cond_q <= '0;
      end else begin
         if (wr_ok && hit_ctrl) ctrl_q <= pwdata;
         if (wr_ok && hit_cond) cond_q <= cond_t'(pwdata[15:0]);
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // ---------------- flash phases ----------------
   logic slow_ph, fast_ph, var_ph;
   lamp_blinker #(
      .SLOW_HALF (SLOW_HALF),
      .FAST_HALF (FAST_HALF),
      .VAR_HALF  (SLOW_HALF / 2)
   ) u_blink (
      .pclk    (pclk),
      .presetn (presetn),
      .slow_ph (slow_ph),
      .fast_ph (fast_ph),
      .var_ph  (var_ph)
   );

   function automatic lamp_t mk(input colour_t c, input flash_t m,
                                input logic s, input logic f, input logic v);
      lamp_t l;
      l.colour = (m == FL_OFF) ? COL_NONE : c;
      l.mode   = m;
      case (m)
         FL_ON:   l.lit = 1'b1;
         FL_SLOW: l.lit = s;
         FL_FAST: l.lit = f;
         FL_VAR:  l.lit = v;
         default: l.lit = 1'b0;
      endcase
      return l;
   endfunction

   // ---------------- state lamp sequencer ----------------
   wire boot_done = (boot_q == 32'(BOOT_CYCLES - 1));
   wire card_err  = cond_q.fw_bad_or_card ||
                    (variant == VAR_PROFINET && cond_q.bad_params);

   always_comb begin
      rdy_d = rdy_q;
      case (rdy_q)
         ST_BOOT: rdy_d = boot_done ? ST_READY : ST_BOOT;
         ST_FW, ST_FAULT, ST_COMM, ST_READY: begin
            // fixed priority once start-up ends
            if (card_err || cond_q.fw_wait_cycle || cond_q.fw_updating) rdy_d = ST_FW;
            else if (ctrl_q[CTRL_FAULT])       rdy_d = ST_FAULT;
            else if (ctrl_q[CTRL_START])       rdy_d = ST_COMM;
            else                               rdy_d = ST_READY;
         end
         // an illegal one-hot code returns to ST_BOOT, which passes straight on since boot_q keeps its final count
         default: rdy_d = ST_BOOT;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_q  <= ST_BOOT;
         boot_q <= 32'h0;
      end else begin
         rdy_q  <= rdy_d;
         boot_q <= (rdy_q == ST_BOOT && !boot_done) ? boot_q + 32'h1 : boot_q;
      end
   end

   // ---------------- lamp decode ----------------
   // red-slow and red-fast state tests gate the fieldbus lamp's network and profibus bus states; serial red fast is not gated
   lamp_t st_d, fb_d, sf_d, lk_d;
   wire st_red_slow = (st_d.colour == COL_RED) && (st_d.mode == FL_SLOW);
   wire st_red_fast = (st_d.colour == COL_RED) && (st_d.mode == FL_FAST);

   always_comb begin
      case (rdy_q)
         ST_BOOT:  st_d = mk(COL_ORANGE, FL_ON, slow_ph, fast_ph, var_ph);
         ST_FW: begin
            if (card_err)                  st_d = mk(COL_RED, FL_FAST, slow_ph, fast_ph, var_ph);
            else if (cond_q.fw_wait_cycle) st_d = mk(COL_RED, FL_SLOW, slow_ph, fast_ph, var_ph);
            else                           st_d = mk(COL_RED, FL_ON, slow_ph, fast_ph, var_ph);
         end
         ST_FAULT: st_d = mk(COL_RED, FL_FAST, slow_ph, fast_ph, var_ph);
         ST_COMM:  st_d = mk(COL_GREEN, FL_SLOW, slow_ph, fast_ph, var_ph);
         ST_READY: st_d = mk(COL_GREEN, FL_ON, slow_ph, fast_ph, var_ph);
         default:  st_d = mk(COL_ORANGE, FL_ON, slow_ph, fast_ph, var_ph);
      endcase
   end

   // firmware states win over every bus variant on this lamp
   always_comb begin
      fb_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
      if (rdy_q == ST_BOOT) begin
         fb_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
      end else if (rdy_q == ST_FW && card_err) begin
         fb_d = mk(COL_RED, FL_FAST, slow_ph, fast_ph, var_ph);
      end else if (rdy_q == ST_FW && cond_q.fw_wait_cycle) begin
         fb_d = mk(COL_RED, FL_SLOW, slow_ph, fast_ph, var_ph);
      end else if (rdy_q == ST_FW) begin
         fb_d = mk(COL_YELLOW, FL_VAR, slow_ph, fast_ph, var_ph);
      end else begin
         case (variant)
            VAR_PROFINET: begin
               if (cond_q.bus_data_active)
                  fb_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
               else if (cond_q.bus_no_link && !st_red_fast)
                  fb_d = mk(COL_RED, FL_FAST, slow_ph, fast_ph, var_ph);
               else if (cond_q.bus_no_data && !st_red_slow)
                  fb_d = mk(COL_RED, FL_SLOW, slow_ph, fast_ph, var_ph);
            end
            VAR_PROFIBUS: begin
               if (cond_q.bus_data_active)
                  fb_d = mk(COL_GREEN, FL_ON, slow_ph, fast_ph, var_ph);
               else if (cond_q.bus_unused)
                  fb_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
               else if ((cond_q.bus_error || cond_q.baud_search || cond_q.bus_no_link)
                        && !st_red_fast)
                  fb_d = mk(COL_RED, FL_FAST, slow_ph, fast_ph, var_ph);
               else if (cond_q.bus_config_fault && !st_red_slow)
                  fb_d = mk(COL_RED, FL_SLOW, slow_ph, fast_ph, var_ph);
            end
            VAR_SERIAL: begin
               if (mon_setting == MON_OFF)
                  fb_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
               else if (cond_q.bus_data_active)
                  fb_d = mk(COL_GREEN, FL_ON, slow_ph, fast_ph, var_ph);
               else if (cond_q.bus_no_link || cond_q.bus_error)
                  fb_d = mk(COL_RED, FL_FAST, slow_ph, fast_ph, var_ph);
            end
            default: fb_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
         endcase
      end
   end

   // safety lamp stays dark during start-up, like the fieldbus and link lamps
   always_comb begin
      if (rdy_q == ST_BOOT)
         sf_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
      else if (cond_q.safety_fault)
         sf_d = mk(COL_YELLOW, FL_FAST, slow_ph, fast_ph, var_ph);
      else if (cond_q.safety_active)
         sf_d = mk(COL_YELLOW, FL_SLOW, slow_ph, fast_ph, var_ph);
      else if (cond_q.safety_enabled)
         sf_d = mk(COL_YELLOW, FL_ON, slow_ph, fast_ph, var_ph);
      else
         sf_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
   end

   // link lamp exists for the network variant only; others keep it dark
   always_comb begin
      if (rdy_q == ST_BOOT || variant != VAR_PROFINET)
         lk_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
      else if (cond_q.pn_naming)
         lk_d = mk(COL_GREEN, FL_SLOW, slow_ph, fast_ph, var_ph);
      else if (cond_q.pn_ok)
         lk_d = mk(COL_GREEN, FL_ON, slow_ph, fast_ph, var_ph);
      else
         lk_d = mk(COL_NONE, FL_OFF, slow_ph, fast_ph, var_ph);
   end

   // registered lamp outputs; one cycle behind rdy_q and the conditions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q   <= '0;
         fb_q   <= '0;
         sf_q   <= '0;
         lk_q   <= '0;
         stop_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         fb_q   <= fb_d;
         sf_q   <= sf_d;
         lk_q   <= lk_d;
         stop_q <= cond_q.safety_fault && rdy_q != ST_BOOT;
      end
   end

   assign state_lamp    = st_q;
   assign fieldbus_lamp = fb_q;
   assign safety_lamp   = sf_q;
   assign link_lamp     = lk_q;
   assign stop_request  = stop_q;

   // ---------------- checks ----------------
   chk_boot_orange: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(presetn) && $past(rdy_q) == ST_BOOT) |-> state_lamp.colour == COL_ORANGE)
      else $error("state lamp not orange during start-up");

   chk_fault_fast: assert property (@(posedge pclk) disable iff (!presetn)
      $past(rdy_q) == ST_FAULT |-> state_lamp.mode == FL_FAST
                                   && state_lamp.colour == COL_RED)
      else $error("fault not shown as red fast");

   chk_card_both: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) == ST_FW && $past(card_err)) |->
         fieldbus_lamp.mode == FL_FAST && state_lamp.mode == FL_FAST)
      else $error("card error not on both lamps");

   chk_safety_stop: assert property (@(posedge pclk) disable iff (!presetn)
      stop_request |-> safety_lamp.mode == FL_FAST)
      else $error("stop without fast safety lamp");

   chk_ready_green: assert property (@(posedge pclk) disable iff (!presetn)
      $past(rdy_q) == ST_READY |-> state_lamp == lamp_t'({COL_GREEN, FL_ON, 1'b1}))
      else $error("ready state not steady green");

   chk_serial_dark: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(variant) == VAR_SERIAL && $past(mon_setting) == MON_OFF
       && $past(rdy_q) inside {ST_READY, ST_COMM, ST_FAULT}) |->
         fieldbus_lamp.mode == FL_OFF)
      else $error("serial fieldbus lamp lit with monitoring off");

   chk_link_off: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(cond_q.pn_ok) == 1'b0 && $past(cond_q.pn_naming) == 1'b0)
         |-> link_lamp.mode == FL_OFF)
      else $error("link lamp lit without communication");

   chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready)
      else $error("apb answer not after one wait");

   chk_wait_slow: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) == ST_FW && $past(cond_q.fw_wait_cycle) && !$past(card_err)) |->
         state_lamp.mode == FL_SLOW && fieldbus_lamp.mode == FL_SLOW)
      else $error("firmware wait not slow on both lamps");

   chk_safe_steady: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) != ST_BOOT && $past(cond_q.safety_enabled) && !$past(cond_q.safety_active)
       && !$past(cond_q.safety_fault)) |-> safety_lamp == lamp_t'({COL_YELLOW, FL_ON, 1'b1}))
      else $error("enabled safety not steady yellow");

   chk_safe_slow: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) != ST_BOOT && $past(cond_q.safety_active) && !$past(cond_q.safety_fault))
         |-> safety_lamp.mode == FL_SLOW) else $error("active safety not slow yellow");

   chk_link_naming: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) != ST_BOOT && $past(variant) == VAR_PROFINET && $past(cond_q.pn_naming))
         |-> link_lamp.mode == FL_SLOW) else $error("naming not shown as slow green");

   chk_link_green: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) != ST_BOOT && $past(variant) == VAR_PROFINET && $past(cond_q.pn_ok)
       && !$past(cond_q.pn_naming)) |-> link_lamp.mode == FL_ON)
      else $error("healthy network not steady green");

   chk_pn_data_off: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) inside {ST_READY, ST_COMM, ST_FAULT} && $past(variant) == VAR_PROFINET
       && $past(cond_q.bus_data_active)) |-> fieldbus_lamp.mode == FL_OFF)
      else $error("fieldbus lamp lit during process data");

   chk_pb_data_green: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(rdy_q) inside {ST_READY, ST_COMM, ST_FAULT} && $past(variant) == VAR_PROFIBUS
       && $past(cond_q.bus_data_active)) |-> fieldbus_lamp.mode == FL_ON)
      else $error("fieldbus lamp not green during data exchange");

   chk_lit_slow: assert property (@(posedge pclk) disable iff (!presetn)
      state_lamp.mode == FL_SLOW |-> state_lamp.lit == $past(slow_ph))
      else $error("slow state lamp out of phase");

   chk_fw_red: assert property (@(posedge pclk) disable iff (!presetn)
      $past(rdy_q) == ST_FW |-> state_lamp.colour == COL_RED)
      else $error("firmware state not shown red");

   chk_comm_slow: assert property (@(posedge pclk) disable iff (!presetn)
      $past(rdy_q) == ST_COMM |-> state_lamp.mode == FL_SLOW && state_lamp.colour == COL_GREEN)
      else $error("commissioning not slow green");
endmodule

// ---- verif/status_lamp_encoder_tb_top.sv ----
// Purpose: self-checking bench for the status lamp encoder, driven over APB
// Assumes: shortened counts BOOT_CYCLES 20, SLOW_HALF 8, FAST_HALF 2
// Notes: lamp levels checked at the ports a few cycles after both registers are written
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module status_lamp_encoder_tb_top import lamp_pkg::*;;
   localparam int unsigned BOOT_N = 20;
   localparam int unsigned SLOW_N = 8;
   localparam int unsigned FAST_N = 2;
   localparam int          LIMIT  = 20000;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   lamp_t       state_lamp;
   lamp_t       fieldbus_lamp;
   lamp_t       safety_lamp;
   lamp_t       link_lamp;
   logic        stop_request;
   int          err_count;
   int          tests_run;
   int          cyc;

   status_lamp_encoder #(
      .BOOT_CYCLES (BOOT_N),
      .SLOW_HALF   (SLOW_N),
      .FAST_HALF   (FAST_N)
   ) dut_u (
      .pclk          (pclk),
      .presetn       (presetn),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .paddr         (paddr),
      .pwdata        (pwdata),
      .prdata        (prdata),
      .pready        (pready),
      .pslverr       (pslverr),
      .state_lamp    (state_lamp),
      .fieldbus_lamp (fieldbus_lamp),
      .safety_lamp   (safety_lamp),
      .link_lamp     (link_lamp),
      .stop_request  (stop_request)
   );

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task print_verdict;
      begin
         $display("mismatches %0d comparisons %0d", err_count, tests_run);
         if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   // a hung bus or stuck wait ends here instead of running forever
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         print_verdict();
      end
   end

   // request held from setup until the edge that samples pready high
   task apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                 output logic [31:0] rd, output logic er);
      begin
         @(posedge pclk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
         end while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task apply(input logic [31:0] ctrl, input logic [31:0] cond);
      logic [31:0] d;
      logic        e;
      begin
         apb_xfer(1'b1, ADDR_CTRL, ctrl, d, e);
         apb_xfer(1'b1, ADDR_COND, cond, d, e);
         repeat (4) @(posedge pclk);
      end
   endtask

   task chk(input string nm, input lamp_t l, input colour_t c, input flash_t m);
      begin
         `CHK({nm, " colour"}, c, l.colour)
         `CHK({nm, " mode"}, m, l.mode)
      end
   endtask

   function automatic logic lit_of(input int w);
      case (w)
         0: return state_lamp.lit;
         1: return fieldbus_lamp.lit;
         2: return safety_lamp.lit;
         default: return link_lamp.lit;
      endcase
   endfunction

   // cycles between two successive changes of a lamp's lit level
   task half_len(input int w, output int n);
      logic l;
      int   k;
      begin
         @(posedge pclk);
         l = lit_of(w);
         k = 0;
         while (lit_of(w) === l && k < 100) begin
            @(posedge pclk);
            k++;
         end
         l = lit_of(w);
         n = 0;
         while (lit_of(w) === l && n < 100) begin
            @(posedge pclk);
            n++;
         end
      end
   endtask

   initial begin
      logic [31:0] rd;
      logic        er;
      int          n;
      logic [31:0] errs [3];
      err_count = 0;
      tests_run = 0;
      cyc       = 0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0000_0000;
      repeat (16) @(posedge pclk);
      `CHK("lamp during reset", 7'h00, state_lamp)
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("boot state", state_lamp, COL_ORANGE, FL_ON);
      apb_xfer(1'b0, 12'h010, 32'h0, rd, er);
      `CHK("unmapped error", 1'b1, er)
      `CHK("unmapped data", 32'h0000_0000, rd)
      repeat (BOOT_N + 5) @(posedge pclk);
      apply(32'h0000_0000, 32'h0000_0000);
      chk("idle state", state_lamp, COL_GREEN, FL_ON);
      apply(32'h0000_0001, 32'h0000_0000);
      chk("commission state", state_lamp, COL_GREEN, FL_SLOW);
      half_len(0, n);
      `CHK("slow half period", SLOW_N, n)
      apply(32'h0000_0003, 32'h0000_0000);
      chk("fault state", state_lamp, COL_RED, FL_FAST);
      half_len(0, n);
      `CHK("fast half period", FAST_N, n)
      apply(32'h0000_0003, 32'h0000_0002);
      chk("wait state", state_lamp, COL_RED, FL_SLOW);
      chk("wait fieldbus", fieldbus_lamp, COL_RED, FL_SLOW);
      for (int i = 0; i < 20; i++) begin
         @(posedge pclk);
         `CHK("slow phase match", state_lamp.lit, fieldbus_lamp.lit)
      end
      apply(32'h0000_0000, 32'h0000_0001);
      chk("card state", state_lamp, COL_RED, FL_FAST);
      chk("card fieldbus", fieldbus_lamp, COL_RED, FL_FAST);
      apply(32'h0000_0000, 32'h0000_0004);
      chk("update state", state_lamp, COL_RED, FL_ON);
      chk("update fieldbus", fieldbus_lamp, COL_YELLOW, FL_VAR);
      apply(32'h0000_0000, 32'h0000_0048);
      chk("safety enabled", safety_lamp, COL_YELLOW, FL_ON);
      chk("link ok", link_lamp, COL_GREEN, FL_ON);
      apply(32'h0000_0000, 32'h0000_0098);
      chk("safety active", safety_lamp, COL_YELLOW, FL_SLOW);
      chk("link naming", link_lamp, COL_GREEN, FL_SLOW);
      apply(32'h0000_0000, 32'h0000_0028);
      chk("safety fault", safety_lamp, COL_YELLOW, FL_FAST);
      `CHK("stop raised", 1'b1, stop_request)
      chk("link none", link_lamp, COL_NONE, FL_OFF);
      apb_xfer(1'b0, ADDR_STATUS, 32'h0, rd, er);
      `CHK("status word", 32'h0000_0030, rd)
      apply(32'h0000_0000, 32'h0000_0E00);
      `CHK("stop cleared", 1'b0, stop_request)
      chk("pn data", fieldbus_lamp, COL_NONE, FL_OFF);
      apply(32'h0000_0000, 32'h0000_0400);
      chk("pn no data", fieldbus_lamp, COL_RED, FL_SLOW);
      apply(32'h0000_0000, 32'h0000_0100);
      chk("pn params state", state_lamp, COL_RED, FL_FAST);
      chk("pn params fieldbus", fieldbus_lamp, COL_RED, FL_FAST);
      apply(32'h0000_0000, 32'h0000_0800);
      chk("pn no link", fieldbus_lamp, COL_RED, FL_FAST);
      chk("pn no link state", state_lamp, COL_GREEN, FL_ON);
      apply(32'h0000_0020, 32'h0000_8800);
      chk("serial dark", fieldbus_lamp, COL_NONE, FL_OFF);
      apply(32'h0000_0120, 32'h0000_0800);
      chk("serial monitored", fieldbus_lamp, COL_RED, FL_FAST);
      apply(32'h0000_0011, 32'h0000_0200);
      apb_xfer(1'b0, ADDR_CTRL, 32'h0, rd, er);
      `CHK("ctrl readback", 32'h0000_0011, rd)
      `CHK("ctrl no error", 1'b0, er)
      apply(32'h0000_0010, 32'h0000_0200);
      chk("pb data", fieldbus_lamp, COL_GREEN, FL_ON);
      apb_xfer(1'b0, ADDR_LAMPS, 32'h0, rd, er);
      `CHK("lamps word", 32'h0264_C000, rd)
      apply(32'h0000_0010, 32'h0000_3000);
      chk("pb unused", fieldbus_lamp, COL_NONE, FL_OFF);
      apply(32'h0000_0010, 32'h0000_2000);
      chk("pb config", fieldbus_lamp, COL_RED, FL_SLOW);
      errs[0] = 32'h0000_8000;
      errs[1] = 32'h0000_4000;
      errs[2] = 32'h0000_0800;
      for (int i = 0; i < 3; i++) begin
         apply(32'h0000_0010, errs[i]);
         chk("pb bus error", fieldbus_lamp, COL_RED, FL_FAST);
      end
      print_verdict();
   end
endmodule
